// file: bemf_timing_pkg.sv
// Package: register map, field layout and timing constants for back-EMF window timing
package bemf_timing_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses = 4 x index)
    // ------------------------------------------------------------
    localparam logic [7:0] WIDE_WINDOW_CONFIG_IDX = 8'h16;
    localparam logic [7:0] NARROW_WINDOW_SKIP_CONFIG_IDX = 8'h17;
    localparam logic [7:0] COMPARATOR_BLANKING_CONFIG_IDX = 8'h18;
    localparam logic [7:0] SKIP_CONFIG_IDX = 8'h20;
    localparam logic [7:0] STATUS_IDX = 8'h21;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] WIDE_RESET = 8'h00;
    localparam logic [7:0] NARROW_RESET = 8'h00;
    localparam logic [7:0] BLANK_RESET = 8'h00;
    localparam logic [15:0] SKIPCFG_RESET = 16'h0000;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 250;
    localparam int BLANK_STEP_REF_CYCLES = 128;
    localparam int BLANK_REF_MHZ10 = 256;
    // Clock cycles per blanking step: 128 / 25.6 MHz = 5 us -> 1250 cycles
    localparam int BLANK_STEP_CYCLES = (BLANK_STEP_REF_CYCLES * CLOCK_MHZ * 10) / BLANK_REF_MHZ10;
    localparam int NARROW_SHIFT = 5;   // 1/32 period
    localparam int BLANK_LIMIT_SHIFT = 6; // 1/64 period
    localparam int WIDE_SHIFT = 5;     // Wide unit taken as 1/32 period too

    typedef struct packed {
        logic [4:0] initialSkip;
        logic [4:0] wideWindow;
        logic [3:0] narrowWindow;
        logic [2:0] postSkip;
        logic [5:0] blankTime;
        logic [6:0] skipThreshold;
        logic autoBrakePeakMeasure;
    } config_s;

    typedef enum logic [1:0] {
        IDLE,
        SKIPPING,
        SENSING
    } sense_e;
endpackage

// file: half_period_counter.sv
// Module: loadable down-counter of half periods, used for both skip counts
`timescale 1ns/10ps
module half_period_counter #(
    parameter int WIDTH = 5
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    input wire logic tick,
    output logic busy
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // Load wins over a tick in the same cycle
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = loadValue;
        end else if (tick && count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign busy = (count != '0);
endmodule

// file: haptic_bemf_window_timing.sv
// Module: back-EMF sensing skip, window sizing and comparator blanking with APB registers
//
// How it works
// - When a vibration pattern starts, sensing waits the initial-skip number of half periods.
// - A change of output polarity reloads the same initial skip before sensing restarts.
// - Amplitude rising back above the skip threshold after dropping below reloads the skip.
// - The wide window length is the 5-bit field times a fraction of the current period.
// - The narrow window length is the 4-bit field times one 32nd of the current period.
// - After each completed detection, detection is skipped for the post-skip half periods.
// - The comparator is blanked at window entry and exit for the 6-bit field times 128 ref ticks.
// - Blanking is limited to a 64th of the period unless peak measure is on in auto braking.
// - Detection is skipped while the absolute amplitude is below the 7-bit threshold.
// - During active-braking half periods both skip settings are ignored.
`timescale 1ns/10ps
module haptic_bemf_window_timing
    import bemf_timing_pkg::*;
#(
    parameter int PERIOD_WIDTH = 20,
    parameter int BLANK_STEP = BLANK_STEP_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic patternStart,
    input wire logic polarity,
    input wire logic halfPeriodTick,
    input wire logic detectDone,
    input wire logic activeBrake,
    input wire logic autoBrakeState,
    input wire logic [7:0] amplitude,
    input wire logic [PERIOD_WIDTH-1:0] sinePeriod,
    input wire logic windowEdge,
    output logic senseEnable,
    output logic comparatorBlank,
    output logic [PERIOD_WIDTH-1:0] wideWindowLength,
    output logic [PERIOD_WIDTH-1:0] narrowWindowLength
);
    // ------------------------------------------------------------
    // Registers and APB slave
    // ------------------------------------------------------------
    config_s cfg;
    config_s next_cfg;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [7:0] wordIndex;
    logic access;
    logic commit;
    logic senseState;

    assign wordIndex = paddr[9:2];
    // Answer in the second access cycle; one wait state keeps prdata registered
    assign access = psel && penable && !pready;
    // A write lands only at the edge where the master sees pready high
    assign commit = psel && penable && pready && pwrite;

    always_comb begin
        next_cfg = cfg;
        next_prdata = prdata;
        next_pready = access;
        next_pslverr = 1'b0;
        if (access) begin
            next_prdata = 32'h0000_0000;
            unique case (wordIndex)
                WIDE_WINDOW_CONFIG_IDX: next_prdata[4:0] = cfg.wideWindow;
                NARROW_WINDOW_SKIP_CONFIG_IDX: begin
                    next_prdata[7:4] = cfg.narrowWindow;
                    next_prdata[2:0] = cfg.postSkip;
                end
                COMPARATOR_BLANKING_CONFIG_IDX: next_prdata[5:0] = cfg.blankTime;
                SKIP_CONFIG_IDX: begin
                    next_prdata[4:0] = cfg.initialSkip;
                    next_prdata[14:8] = cfg.skipThreshold;
                    next_prdata[15] = cfg.autoBrakePeakMeasure;
                end
                STATUS_IDX: begin
                    next_prdata[0] = senseEnable;
                    next_prdata[1] = comparatorBlank;
                    next_prdata[2] = senseState;
                    next_pslverr = pwrite;
                end
                default: next_pslverr = 1'b1; // Unmapped address
            endcase
        end
        if (commit) begin
            unique case (wordIndex)
                WIDE_WINDOW_CONFIG_IDX: next_cfg.wideWindow = pwdata[4:0];
                NARROW_WINDOW_SKIP_CONFIG_IDX: begin
                    next_cfg.narrowWindow = pwdata[7:4];
                    next_cfg.postSkip = pwdata[2:0];
                end
                COMPARATOR_BLANKING_CONFIG_IDX: next_cfg.blankTime = pwdata[5:0];
                SKIP_CONFIG_IDX: begin
                    next_cfg.initialSkip = pwdata[4:0];
                    next_cfg.skipThreshold = pwdata[14:8];
                    next_cfg.autoBrakePeakMeasure = pwdata[15];
                end
                default: next_cfg = cfg; // Status and unmapped words take no write
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cfg <= '{initialSkip: SKIPCFG_RESET[4:0], wideWindow: WIDE_RESET[4:0],
                     narrowWindow: NARROW_RESET[7:4], postSkip: NARROW_RESET[2:0],
                     blankTime: BLANK_RESET[5:0], skipThreshold: SKIPCFG_RESET[14:8],
                     autoBrakePeakMeasure: SKIPCFG_RESET[15]};
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            cfg <= next_cfg;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Skip control
    // ------------------------------------------------------------
    logic lastPolarity;
    logic belowThreshold;
    logic lowAmplitude;
    logic initialLoad;
    logic postLoad;
    logic initialBusy;
    logic postBusy;
    logic skipTick;

    // Absolute amplitude is the low seven bits
    assign lowAmplitude = amplitude[6:0] < cfg.skipThreshold;
    // Active braking masks both skip counts and holds them still
    assign skipTick = halfPeriodTick && !activeBrake;
    assign initialLoad = patternStart
        || (polarity != lastPolarity)
        || (belowThreshold && !lowAmplitude);
    assign postLoad = detectDone && !activeBrake;

    always_ff @(posedge clock) begin
        if (srst) begin
            lastPolarity <= 1'b0;
            belowThreshold <= 1'b0;
        end else begin
            lastPolarity <= polarity;
            belowThreshold <= lowAmplitude;
        end
    end

    half_period_counter #(.WIDTH(5)) initialCounter (
        .clock(clock),
        .srst(srst),
        .load(initialLoad),
        .loadValue(cfg.initialSkip),
        .tick(skipTick),
        .busy(initialBusy)
    );

    half_period_counter #(.WIDTH(3)) postCounter (
        .clock(clock),
        .srst(srst),
        .load(postLoad),
        .loadValue(cfg.postSkip),
        .tick(skipTick),
        .busy(postBusy)
    );

    // Sensing allowed when amplitude is not below threshold, no initial skip is being loaded, and either no skip is pending or active braking is on
    logic next_senseEnable;
    assign next_senseEnable = !lowAmplitude && !initialLoad
        && (activeBrake || (!initialBusy && !postBusy));
    assign senseState = initialBusy || postBusy;

    // ------------------------------------------------------------
    // Window lengths and blanking
    // ------------------------------------------------------------
    logic [PERIOD_WIDTH-1:0] next_wide;
    logic [PERIOD_WIDTH-1:0] next_narrow;
    logic [PERIOD_WIDTH+5:0] blankRequest;
    logic [PERIOD_WIDTH+5:0] blankLimit;
    logic [PERIOD_WIDTH+5:0] blankLoad;
    logic [PERIOD_WIDTH+5:0] blankCount;
    logic [PERIOD_WIDTH+5:0] next_blankCount;
    logic unlimited;

    // Products truncated to the period width; fields never exceed a full period
    assign next_wide = PERIOD_WIDTH'((sinePeriod >> WIDE_SHIFT) * cfg.wideWindow);
    assign next_narrow = PERIOD_WIDTH'((sinePeriod >> NARROW_SHIFT) * cfg.narrowWindow);
    assign blankRequest = (PERIOD_WIDTH+6)'(cfg.blankTime * BLANK_STEP);
    assign blankLimit = (PERIOD_WIDTH+6)'(sinePeriod >> BLANK_LIMIT_SHIFT);
    assign unlimited = cfg.autoBrakePeakMeasure && autoBrakeState;
    // Clamp instead of letting blanking eat into the window
    assign blankLoad = (!unlimited && blankRequest > blankLimit) ? blankLimit
        : blankRequest;

    // Every window entry or exit edge restarts the blanking interval
    always_comb begin
        next_blankCount = blankCount;
        if (windowEdge) begin
            next_blankCount = blankLoad;
        end else if (blankCount != '0) begin
            next_blankCount = blankCount - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            blankCount <= '0;
            comparatorBlank <= 1'b0;
            senseEnable <= 1'b0;
            wideWindowLength <= '0;
            narrowWindowLength <= '0;
        end else begin
            blankCount <= next_blankCount;
            comparatorBlank <= (next_blankCount != '0);
            senseEnable <= next_senseEnable;
            wideWindowLength <= next_wide;
            narrowWindowLength <= next_narrow;
        end
    end
endmodule

// file: haptic_bemf_window_timing_assertions.sv
// Checker: port-level assertions for back-EMF window timing
`timescale 1ns/10ps
module haptic_bemf_window_timing_assertions
    import bemf_timing_pkg::*;
#(
    parameter int PERIOD_WIDTH = 20
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic patternStart,
    input wire logic polarity,
    input wire logic autoBrakeState,
    input wire logic [PERIOD_WIDTH-1:0] sinePeriod,
    input wire logic windowEdge,
    input wire logic senseEnable,
    input wire logic comparatorBlank,
    input wire logic [PERIOD_WIDTH-1:0] wideWindowLength,
    input wire logic [PERIOD_WIDTH-1:0] narrowWindowLength
);
    // Length of the running blank, with the limit in force when it was loaded,
    // so a period change in mid-blank does not move the goalposts
    logic exempt;
    logic [PERIOD_WIDTH-1:0] run;
    logic [PERIOD_WIDTH-1:0] limit;
    always_ff @(posedge clock) begin
        if (srst) begin
            run <= '0;
            limit <= '0;
            exempt <= 1'b0;
        end else if (windowEdge) begin
            run <= '0;
            limit <= sinePeriod >> BLANK_LIMIT_SHIFT;
            exempt <= autoBrakeState;
        end else begin
            run <= comparatorBlank ? run + 1'b1 : '0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_narrow_bound; narrowWindowLength <= ($past(sinePeriod) >> 5) * 15; endproperty
    a_narrow_bound: assert property (p_narrow_bound) else $error("narrow too long");
    property p_wide_bound; wideWindowLength <= ($past(sinePeriod) >> 5) * 31; endproperty
    a_wide_bound: assert property (p_wide_bound) else $error("wide too long");
    property p_blank_cause; $rose(comparatorBlank) |-> $past(windowEdge); endproperty
    a_blank_cause: assert property (p_blank_cause) else $error("blank without edge");
    property p_blank_limit; exempt || run <= limit; endproperty
    a_blank_limit: assert property (p_blank_limit) else $error("blank over limit");
    property p_pattern_hold; patternStart |=> !senseEnable; endproperty
    a_pattern_hold: assert property (p_pattern_hold) else $error("sense at start");
    property p_polarity_hold; polarity != $past(polarity) |=> !senseEnable; endproperty
    a_polarity_hold: assert property (p_polarity_hold) else $error("sense at flip");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_ready_cause; pready |-> $past(psel && penable); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready unasked");
    property p_reset_quiet; disable iff (1'b0) srst |=> !senseEnable && !pready; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("busy in reset");
endmodule
bind haptic_bemf_window_timing haptic_bemf_window_timing_assertions #(
    .PERIOD_WIDTH(PERIOD_WIDTH)) checker_inst (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pready(pready), .patternStart(patternStart), .polarity(polarity),
    .autoBrakeState(autoBrakeState), .sinePeriod(sinePeriod), .windowEdge(windowEdge),
    .senseEnable(senseEnable), .comparatorBlank(comparatorBlank),
    .wideWindowLength(wideWindowLength), .narrowWindowLength(narrowWindowLength));

// file: actuator_coil_model.sv
// Model: actuator coil side, half-period ticks and window edges
`timescale 1ns/10ps
module actuator_coil_model #(
    parameter int HALF = 6
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic fire,
    output logic halfPeriodTick = 1'b0,
    output logic windowEdge = 1'b0
);
    int cnt;
    // A half period after each request the coil crosses; both strobes last one cycle
    always @(posedge clock) begin
        if (srst) begin
            cnt <= 0;
        end else if (fire) begin
            cnt <= HALF;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        halfPeriodTick <= !srst && !fire && (cnt == 1);
        windowEdge <= !srst && !fire && (cnt == 1);
    end
endmodule

// file: haptic_bemf_window_timing_tb.sv
// Testbench: registers, skip counts, windows and blanking against a bench model
`timescale 1ns/10ps
module haptic_bemf_window_timing_tb;
    import bemf_timing_pkg::*;
    localparam int BS = 2;
    localparam int HALF = 6;
    localparam logic [7:0] IX [5] = '{WIDE_WINDOW_CONFIG_IDX, NARROW_WINDOW_SKIP_CONFIG_IDX,
        COMPARATOR_BLANKING_CONFIG_IDX, SKIP_CONFIG_IDX, STATUS_IDX};
    localparam logic [31:0] MK [4] = '{32'h1F, 32'hF7, 32'h3F, 32'hFF1F};
    logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, e, fire = 0;
    logic patternStart = 0, polarity = 0, detectDone = 0, activeBrake = 0, autoBrakeState = 0;
    logic pready, pslverr, halfPeriodTick, windowEdge, senseEnable, comparatorBlank;
    logic [31:0] paddr = 0, pwdata = 0, prdata, q;
    logic [31:0] model [4];
    logic [7:0] amplitude = 8'h64, lf = 8'h3D;
    logic [19:0] sinePeriod = 20'd1024, wideLen, narrowLen;
    int miscompares = 0, checks = 0, ex, n;
    haptic_bemf_window_timing #(.PERIOD_WIDTH(20), .BLANK_STEP(BS))
        haptic_bemf_window_timing_inst (
        .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .patternStart(patternStart), .polarity(polarity), .halfPeriodTick(halfPeriodTick),
        .detectDone(detectDone), .activeBrake(activeBrake), .autoBrakeState(autoBrakeState),
        .amplitude(amplitude), .sinePeriod(sinePeriod), .windowEdge(windowEdge),
        .senseEnable(senseEnable), .comparatorBlank(comparatorBlank),
        .wideWindowLength(wideLen), .narrowWindowLength(narrowLen));
    actuator_coil_model #(.HALF(HALF)) actuator_coil_model_inst (.clock(clock), .srst(srst),
        .fire(fire), .halfPeriodTick(halfPeriodTick), .windowEdge(windowEdge));
    always #2 clock = ~clock;
    // ----
    // Helpers
    // ----
    function automatic logic [7:0] nextRand();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; a gap edge first so psel never changes twice in a step
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Sensing must stay off for k coil half periods, then come back
    task automatic skipRun(input int k);
        repeat (3) @(posedge clock);
        for (int i = 0; i < k; i++) begin
            chk(senseEnable, 0);
            fire <= 1'b1;
            @(posedge clock);
            fire <= 1'b0;
            repeat (HALF + 3) @(posedge clock);
        end
        chk(senseEnable, 1);
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog: the sequence needs a few hundred cycles
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(0, IX[i], 0);
            // Status: sensing is allowed out of reset, threshold 0 and no skip pending
            chk(q, (i == 4) ? 32'h1 : 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            model[i] = {16'h0, nextRand(), nextRand()} & MK[i];
            apb(1, IX[i], model[i] | ~MK[i]);
            apb(0, IX[i], 0);
            chk(q, model[i]);
        end
        apb(0, 8'h30, 0);
        chk(e, 1);
        apb(1, STATUS_IDX, 32'h7);
        chk(e, 1);
        sinePeriod <= {4'h0, nextRand(), 8'h00};
        repeat (3) @(posedge clock);
        chk(wideLen, (sinePeriod >> 5) * model[0][4:0]);
        chk(narrowLen, (sinePeriod >> 5) * model[1][7:4]);
        apb(1, NARROW_WINDOW_SKIP_CONFIG_IDX, 32'h52);
        apb(1, SKIP_CONFIG_IDX, 32'h1403);
        patternStart <= 1'b1;
        @(posedge clock);
        patternStart <= 1'b0;
        skipRun(3);
        polarity <= 1'b1;
        skipRun(3);
        detectDone <= 1'b1;
        @(posedge clock);
        detectDone <= 1'b0;
        skipRun(2);
        amplitude <= 8'h8A;
        repeat (3) @(posedge clock);
        chk(senseEnable, 0);
        amplitude <= 8'hE4;
        skipRun(3);
        activeBrake <= 1'b1;
        polarity <= 1'b0;
        skipRun(0);
        activeBrake <= 1'b0;
        sinePeriod <= 20'd1024;
        // Short, clamped and exempt blanking: 5, 20 and 20 steps
        for (int i = 0; i < 3; i++) begin
            apb(1, COMPARATOR_BLANKING_CONFIG_IDX, (i == 0) ? 32'd5 : 32'd20);
            apb(1, SKIP_CONFIG_IDX, (i == 2) ? 32'h9403 : 32'h1403);
            autoBrakeState <= (i == 2);
            ex = ((i == 0) ? 5 : 20) * BS;
            if (i != 2 && ex > (1024 >> 6))
                ex = 1024 >> 6;
            fire <= 1'b1;
            @(posedge clock);
            fire <= 1'b0;
            while (windowEdge !== 1'b1) @(posedge clock);
            n = 0;
            @(posedge clock);
            while (comparatorBlank === 1'b1 && n < 200) begin
                n++;
                @(posedge clock);
            end
            chk(n, ex);
        end
        report_and_stop();
    end
endmodule
